// File: verilog/ram_regs.svh
`ifndef RAM_REGS_SVH
`define RAM_REGS_SVH

// register indices; byte address is four times the index
`define RAM_IDX_PHYS5      8'h62
`define RAM_IDX_PHYS6      8'h63
`define RAM_IDX_PHYS7      8'h64
`define RAM_IDX_ALIAS0     8'h65
`define RAM_IDX_ALIAS1     8'h66
`define RAM_IDX_ALIAS2     8'h67
`define RAM_IDX_STATUS     8'h70

// field positions
`define RAM_ADDR_MSB       7
`define RAM_ADDR_LSB       1
`define RAM_AUTO_ACK_BIT   0
`define RAM_STAT_BUSY_BIT  0
`define RAM_STAT_HIT_BIT   1
`define RAM_STAT_IDX_LSB   4

// reset values
`define RAM_ENTRY_RESET    8'h00

// bus figures
`define RAM_BUS_ADDR_W     10
`define RAM_BUS_DATA_W     32
`define RAM_ENTRIES        3

`endif

// File: verilog/ram_pkg.sv
package ram_pkg;

  typedef logic [6:0] ram_i2c_addr_t;

  typedef enum logic [1:0]
  {
    RAM_IDLE,
    RAM_WAIT_REMOTE,
    RAM_ACTIVE
  } ram_state_t;

endpackage : ram_pkg

// File: verilog/ram_entry_if.sv
`timescale 1ns/100ps
`default_nettype none

interface ram_entry_if;
  import ram_pkg::*;

  ram_i2c_addr_t alias_addr;
  ram_i2c_addr_t probe_addr;
  logic          hit;

  modport table_side
  (
    output alias_addr,
    output probe_addr,
    input  hit
  );

  modport matcher_side
  (
    input  alias_addr,
    input  probe_addr,
    output hit
  );

endinterface : ram_entry_if

`default_nettype wire

// File: verilog/ram_alias_match.sv
`timescale 1ns/100ps
`default_nettype none

module ram_alias_match
  import ram_pkg::*;
(
  ram_entry_if.matcher_side ent
);

  // a zero alias disables the entry
  assign ent.hit = (ent.alias_addr != 7'h00) && (ent.alias_addr == ent.probe_addr);

endmodule : ram_alias_match

`default_nettype wire

// File: verilog/remote_i2c_alias_remap.sv
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "ram_regs.svh"

// Notes on behaviour
// - Target entries hold a 7-bit physical address in bits 7:1; bit 0 reads zero.
// - On an alias match the stored physical address replaces the forwarded target address.
// - Alias entries hold a 7-bit alias in bits 7:1, compared with incoming addresses.
// - Alias entry N pairs with target entry N+5 (ALIAS0 with PHYS5) for substitution.
// - An alias value of zero never matches, disabling that entry.
// - Auto-ack bit set: every write to that target is acknowledged locally.
// - After reset all aliases, targets and auto-ack bits are zero.
module remote_i2c_alias_remap
  import ram_pkg::*;
#(
  parameter int NUM_ENTRIES = `RAM_ENTRIES
)
(
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic [`RAM_BUS_ADDR_W-1:0]   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [3:0]                   avs_byteenable,
  input  wire logic [`RAM_BUS_DATA_W-1:0]   avs_writedata,
  output logic      [`RAM_BUS_DATA_W-1:0]   avs_readdata,
  output logic                              avs_waitrequest,
  input  wire logic                         i2c_addr_valid,
  input  wire logic [6:0]                   i2c_addr,
  input  wire logic                         i2c_rnw,
  input  wire logic                         i2c_byte_valid,
  input  wire logic                         i2c_stop,
  input  wire logic                         remote_resp_valid,
  input  wire logic                         remote_ack,
  output logic                              fwd_start,
  output logic      [6:0]                   fwd_addr,
  output logic                              fwd_rnw,
  output logic                              fwd_byte,
  output logic                              addr_miss,
  output logic                              local_resp_valid,
  output logic                              local_ack
);

  if (NUM_ENTRIES < 1 || NUM_ENTRIES > `RAM_ENTRIES)
  begin : g_bad_entries
    $error("NUM_ENTRIES must lie between 1 and 3");
  end

  // register storage
  ram_i2c_addr_t  phys_q  [NUM_ENTRIES];
  ram_i2c_addr_t  phys_d  [NUM_ENTRIES];
  ram_i2c_addr_t  alias_q [NUM_ENTRIES];
  ram_i2c_addr_t  alias_d [NUM_ENTRIES];
  logic           auto_q  [NUM_ENTRIES];
  logic           auto_d  [NUM_ENTRIES];

  // bus slave state
  logic [`RAM_BUS_DATA_W-1:0]  rdata_q;
  logic [`RAM_BUS_DATA_W-1:0]  rdata_d;
  logic                        wait_q;
  logic                        wait_d;

  // transaction state
  ram_state_t     state_q;
  ram_state_t     state_d;
  logic           auto_wr_q;
  logic           auto_wr_d;
  logic           last_hit_q;
  logic           last_hit_d;
  logic [1:0]     last_idx_q;
  logic [1:0]     last_idx_d;
  logic           fwd_start_q;
  logic           fwd_start_d;
  ram_i2c_addr_t  fwd_addr_q;
  ram_i2c_addr_t  fwd_addr_d;
  logic           fwd_rnw_q;
  logic           fwd_rnw_d;
  logic           fwd_byte_q;
  logic           fwd_byte_d;
  logic           miss_q;
  logic           miss_d;
  logic           lresp_q;
  logic           lresp_d;
  logic           lack_q;
  logic           lack_d;

  // address matching
  logic           hit_vec [NUM_ENTRIES];
  logic           any_hit;
  logic [1:0]     hit_idx;

  for (genvar gi = 0; gi < NUM_ENTRIES; gi++)
  begin : g_entry
    ram_entry_if ent ();
    assign ent.alias_addr = alias_q[gi];
    assign ent.probe_addr = i2c_addr;
    assign hit_vec[gi]    = ent.hit;
    ram_alias_match u_match
    (
      .ent (ent)
    );
  end

  // lowest matching entry wins
  always_comb
  begin
    any_hit = 1'b0;
    hit_idx = 2'd0;
    for (int i = NUM_ENTRIES - 1; i >= 0; i--)
    begin
      if (hit_vec[i])
      begin
        any_hit = 1'b1;
        hit_idx = i[1:0];
      end
    end
  end

  // bus decode
  logic        bus_req;
  logic        bus_take;
  logic [7:0]  bus_idx;
  logic        bus_aligned;

  assign bus_req     = avs_read | avs_write;
  assign bus_take    = bus_req & ~wait_q;
  assign bus_idx     = avs_address[9:2];
  assign bus_aligned = (avs_address[1:0] == 2'b00);

  // register read and write
  always_comb
  begin
    logic [7:0] rd_byte;
    rd_byte = 8'h00;
    for (int i = 0; i < NUM_ENTRIES; i++)
    begin
      phys_d[i]  = phys_q[i];
      alias_d[i] = alias_q[i];
      auto_d[i]  = auto_q[i];
    end
    // one wait cycle, then a one-cycle answer
    wait_d  = ~(bus_req & wait_q);
    rdata_d = rdata_q;

    if (bus_req && wait_q && bus_aligned)
    begin
      for (int i = 0; i < NUM_ENTRIES; i++)
      begin
        if (bus_idx == (`RAM_IDX_PHYS5 + 8'(i)))
        begin
          rd_byte = {phys_q[i], 1'b0};
        end
        if (bus_idx == (`RAM_IDX_ALIAS0 + 8'(i)))
        begin
          rd_byte = {alias_q[i], auto_q[i]};
        end
      end
      if (bus_idx == `RAM_IDX_STATUS)
      begin
        rd_byte = 8'h00;
        rd_byte[`RAM_STAT_BUSY_BIT] = (state_q != RAM_IDLE);
        rd_byte[`RAM_STAT_HIT_BIT]  = last_hit_q;
        rd_byte[`RAM_STAT_IDX_LSB +: 2] = last_idx_q;
      end
    end
    if (bus_req && wait_q)
    begin
      rdata_d = {24'h000000, rd_byte};
    end

    if (avs_write && bus_take && bus_aligned && avs_byteenable[0])
    begin
      for (int i = 0; i < NUM_ENTRIES; i++)
      begin
        if (bus_idx == (`RAM_IDX_PHYS5 + 8'(i)))
        begin
          phys_d[i] = avs_writedata[`RAM_ADDR_MSB:`RAM_ADDR_LSB];
        end
        if (bus_idx == (`RAM_IDX_ALIAS0 + 8'(i)))
        begin
          alias_d[i] = avs_writedata[`RAM_ADDR_MSB:`RAM_ADDR_LSB];
          auto_d[i]  = avs_writedata[`RAM_AUTO_ACK_BIT];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_ENTRIES; i++)
      begin
        phys_q[i]  <= 7'h00;
        alias_q[i] <= 7'h00;
        auto_q[i]  <= 1'b0;
      end
      rdata_q <= 32'h00000000;
      wait_q  <= 1'b1;
    end
    else
    begin
      for (int i = 0; i < NUM_ENTRIES; i++)
      begin
        phys_q[i]  <= phys_d[i];
        alias_q[i] <= alias_d[i];
        auto_q[i]  <= auto_d[i];
      end
      rdata_q <= rdata_d;
      wait_q  <= wait_d;
    end
  end

  // transaction sequencing
  always_comb
  begin
    state_d     = state_q;
    auto_wr_d   = auto_wr_q;
    last_hit_d  = last_hit_q;
    last_idx_d  = last_idx_q;
    fwd_start_d = 1'b0;
    fwd_addr_d  = fwd_addr_q;
    fwd_rnw_d   = fwd_rnw_q;
    fwd_byte_d  = 1'b0;
    miss_d      = 1'b0;
    lresp_d     = 1'b0;
    lack_d      = lack_q;

    unique case (state_q)
      RAM_IDLE:
      begin
        if (i2c_addr_valid)
        begin
          last_hit_d = any_hit;
          if (any_hit)
          begin
            last_idx_d  = hit_idx;
            fwd_start_d = 1'b1;
            fwd_addr_d  = phys_q[hit_idx];
            fwd_rnw_d   = i2c_rnw;
            auto_wr_d   = auto_q[hit_idx] & ~i2c_rnw;
            if (auto_q[hit_idx] && !i2c_rnw)
            begin
              lresp_d = 1'b1;
              lack_d  = 1'b1;
              state_d = RAM_ACTIVE;
            end
            else
            begin
              state_d = RAM_WAIT_REMOTE;
            end
          end
          else
          begin
            miss_d = 1'b1;
          end
        end
      end
      RAM_WAIT_REMOTE:
      begin
        if (i2c_stop)
        begin
          state_d = RAM_IDLE;
        end
        else if (remote_resp_valid)
        begin
          lresp_d = 1'b1;
          lack_d  = remote_ack;
          state_d = remote_ack ? RAM_ACTIVE : RAM_IDLE;
        end
      end
      RAM_ACTIVE:
      begin
        if (i2c_stop)
        begin
          state_d = RAM_IDLE;
        end
        else if (i2c_byte_valid)
        begin
          fwd_byte_d = 1'b1;
          if (auto_wr_q)
          begin
            lresp_d = 1'b1;
            lack_d  = 1'b1;
          end
          else
          begin
            state_d = RAM_WAIT_REMOTE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= RAM_IDLE;
      auto_wr_q   <= 1'b0;
      last_hit_q  <= 1'b0;
      last_idx_q  <= 2'd0;
      fwd_start_q <= 1'b0;
      fwd_addr_q  <= 7'h00;
      fwd_rnw_q   <= 1'b0;
      fwd_byte_q  <= 1'b0;
      miss_q      <= 1'b0;
      lresp_q     <= 1'b0;
      lack_q      <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      auto_wr_q   <= auto_wr_d;
      last_hit_q  <= last_hit_d;
      last_idx_q  <= last_idx_d;
      fwd_start_q <= fwd_start_d;
      fwd_addr_q  <= fwd_addr_d;
      fwd_rnw_q   <= fwd_rnw_d;
      fwd_byte_q  <= fwd_byte_d;
      miss_q      <= miss_d;
      lresp_q     <= lresp_d;
      lack_q      <= lack_d;
    end
  end

  assign avs_readdata     = rdata_q;
  assign avs_waitrequest  = wait_q;
  assign fwd_start        = fwd_start_q;
  assign fwd_addr         = fwd_addr_q;
  assign fwd_rnw          = fwd_rnw_q;
  assign fwd_byte         = fwd_byte_q;
  assign addr_miss        = miss_q;
  assign local_resp_valid = lresp_q;
  assign local_ack        = lack_q;

endmodule : remote_i2c_alias_remap

`default_nettype wire

// File: dv/ram_props.sv
`timescale 1ns/100ps
`default_nettype none
module ram_props
#(
  parameter int NUM_ENTRIES = 3
)
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        i2c_addr_valid,
  input wire logic [6:0]  i2c_addr,
  input wire logic        i2c_rnw,
  input wire logic        remote_resp_valid,
  input wire logic        remote_ack,
  input wire logic        fwd_start,
  input wire logic        fwd_rnw,
  input wire logic        fwd_byte,
  input wire logic        addr_miss,
  input wire logic        local_resp_valid,
  input wire logic        local_ack
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  bus_answer_a: assert property
    ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
  upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  res_bit_a: assert property
    (!avs_waitrequest && $past(avs_read) && $past(avs_address[9:2]) inside {8'h62, 8'h63, 8'h64}
     |-> !avs_readdata[0])
    else $error("target bit 0 not zero");
  fwd_cause_a: assert property
    (fwd_start |-> $past(i2c_addr_valid) && fwd_rnw == $past(i2c_rnw))
    else $error("forward without cause");
  zero_alias_a: assert property (fwd_start |-> $past(i2c_addr) != 7'h00)
    else $error("zero alias matched");
  miss_cause_a: assert property (addr_miss |-> $past(i2c_addr_valid) && !fwd_start)
    else $error("bad miss pulse");
  read_wait_a: assert property (fwd_start && fwd_rnw |-> !local_resp_valid)
    else $error("read acknowledged locally");
  auto_ack_a: assert property
    (local_resp_valid && (fwd_start || fwd_byte) |-> local_ack && !fwd_rnw)
    else $error("local ack wrong");
  remote_ack_a: assert property
    (local_resp_valid && !fwd_start && !fwd_byte
     |-> $past(remote_resp_valid) && local_ack == $past(remote_ack))
    else $error("remote ack not passed");
  reset_out_a: assert property
    ($rose(rst_n) |-> avs_waitrequest && !fwd_start && !local_resp_valid)
    else $error("outputs not reset");
endmodule : ram_props
bind remote_i2c_alias_remap ram_props #(.NUM_ENTRIES(NUM_ENTRIES)) props_u (.*);
`default_nettype wire

// File: dv/ram_remote_model.sv
`timescale 1ns/100ps
`default_nettype none
module ram_remote_model
(
  input  wire logic       clk,
  input  wire logic       fwd_start,
  input  wire logic       fwd_byte,
  input  wire logic       ack_val,
  input  wire logic [3:0] dly,
  output logic            remote_resp_valid,
  output wire logic       remote_ack
);
  initial remote_resp_valid = 1'b0;
  // line not meaningful outside a response
  assign remote_ack = remote_resp_valid ? ack_val : !ack_val;
  always @(posedge clk)
  begin
    if (fwd_start || fwd_byte)
    begin
      repeat (dly) @(posedge clk);
      remote_resp_valid <= 1'b1;
      @(posedge clk);
      remote_resp_valid <= 1'b0;
    end
  end
endmodule : ram_remote_model
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed
  {
    logic [6:0] a;
    logic       rnw;
    logic       hit;
    logic [6:0] p;
    logic       auto_ack;
    logic       ack;
    logic [3:0] dly;
  } ram_row_t;
  localparam ram_row_t ROWS [5] = '{
    {7'h21, 2'b01, 7'h50, 2'b10, 4'h0}, {7'h21, 2'b11, 7'h50, 2'b10, 4'h2},
    {7'h30, 2'b01, 7'h51, 2'b01, 4'h3}, {7'h00, 2'b00, 7'h00, 2'b00, 4'h0},
    {7'h45, 2'b10, 7'h00, 2'b00, 4'h0}};
  // index, write value, read-back value
  localparam logic [23:0] CFG [6] = '{24'h62a1a0, 24'h63a2a2, 24'h64a4a4,
    24'h654343, 24'h666060, 24'h670101};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  avs_address = 10'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        i2c_addr_valid = 1'b0;
  logic [6:0]  i2c_addr = 7'h0;
  logic        i2c_rnw = 1'b0;
  logic        i2c_byte_valid = 1'b0;
  logic        i2c_stop = 1'b0;
  logic        remote_resp_valid;
  logic        remote_ack;
  logic        fwd_start;
  logic [6:0]  fwd_addr;
  logic        fwd_rnw;
  logic        fwd_byte;
  logic        addr_miss;
  logic        local_resp_valid;
  logic        local_ack;
  logic        ack_val = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic [7:0]  q;
  int          n_errors = 0;
  int          samples_checked = 0;
  always #25 clk = ~clk;
  remote_i2c_alias_remap dut_u (.*);
  ram_remote_model remote_u (.*);
  task test_done();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  task bad(input string m);
    n_errors++;
    $display("Error at %0t: %s", $time, m);
  endtask : bad
  task chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e)
      bad($sformatf("saw %h want %h", s, e));
  endtask : chk
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be,
           output logic [7:0] r);
    int n;
    @(posedge clk);
    avs_address    <= {idx, 2'b00};
    avs_read       <= !w;
    avs_write      <= w;
    avs_byteenable <= be;
    avs_writedata  <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    r = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      bad("bus timeout");
      test_done();
    end
  endtask : bus
  task waitresp(input logic e);
    int n;
    n = 0;
    while (local_resp_valid !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (local_resp_valid !== 1'b1)
    begin
      bad("no response");
      test_done();
    end
    chk({7'h0, local_ack}, {7'h0, e});
  endtask : waitresp
  task pulse(input logic is_stop);
    @(posedge clk);
    i2c_byte_valid <= !is_stop;
    i2c_stop       <= is_stop;
    @(posedge clk);
    i2c_byte_valid <= 1'b0;
    i2c_stop       <= 1'b0;
    #1;
  endtask : pulse
  task run(input ram_row_t r);
    @(posedge clk);
    ack_val        <= r.ack;
    dly            <= r.dly;
    i2c_addr       <= r.a;
    i2c_rnw        <= r.rnw;
    i2c_addr_valid <= 1'b1;
    @(posedge clk);
    i2c_addr_valid <= 1'b0;
    #1;
    chk({5'h0, fwd_start, addr_miss, local_resp_valid},
        {5'h0, r.hit, !r.hit, r.hit && r.auto_ack && !r.rnw});
    if (r.hit)
      chk({fwd_rnw, fwd_addr}, {r.rnw, r.p});
    if (r.hit && (r.rnw || !r.auto_ack))
      waitresp(r.ack);
    if (r.hit && !r.rnw && (r.auto_ack || r.ack))
    begin
      pulse(1'b0);
      chk({6'h0, fwd_byte, local_resp_valid}, {6'h0, 1'b1, r.auto_ack});
      if (!r.auto_ack)
        waitresp(r.ack);
    end
    pulse(1'b1);
    repeat (2) @(posedge clk);
  endtask : run
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, CFG[i][23:16], 8'h00, 4'h1, q);
      chk(q, 8'h00);
      bus(1'b1, CFG[i][23:16], CFG[i][15:8], 4'h1, q);
      bus(1'b0, CFG[i][23:16], 8'h00, 4'h1, q);
      chk(q, CFG[i][7:0]);
    end
    for (int i = 0; i < 5; i++)
      run(ROWS[i]);
    // status: idle, last lookup missed, last hit was entry 1
    bus(1'b0, 8'h70, 8'h00, 4'h1, q);
    chk(q, 8'h10);
    // disabled lane and unmapped index
    bus(1'b1, 8'h65, 8'hff, 4'h0, q);
    bus(1'b1, 8'h7f, 8'hff, 4'h1, q);
    bus(1'b0, 8'h7f, 8'h00, 4'h1, q);
    chk(q, 8'h00);
    bus(1'b0, 8'h65, 8'h00, 4'h1, q);
    chk(q, 8'h43);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 8'h65, 8'h00, 4'h1, q);
    chk(q, 8'h00);
    run({7'h21, 2'b00, 7'h00, 2'b00, 4'h0});
    test_done();
  end
endmodule : tb
`default_nettype wire
